// >>> inc/oe_gate_pkg.sv
// oe_gate_pkg: constants, states and carriers for the clock output enable gate.
// assumes one system clock; pins arrive unsynchronised from the board.
package oe_gate_pkg;

    localparam int          NUM_OUTPUTS  = 10;
    localparam int          SYNC_STAGES  = 3;
    localparam int          CLOCK_HZ     = 10_000_000;
    localparam int          CLOCK_NS     = 100;
    localparam int          MAX_RESUME_CYCLES = 2;

    localparam logic [1:0]  PIN_RESET    = 2'h0;
    localparam logic        LEVEL_LOW    = 1'b0;

    // field positions in the sampled pin word
    localparam int          PIN_REF_BIT  = 0;
    localparam int          PIN_EN_BIT   = 1;
    localparam int          PIN_COUNT    = 2;

    typedef enum logic [1:0] {
        ST_HIZ      = 2'b00,
        ST_LOW      = 2'b01,
        ST_RUN      = 2'b10,
        ST_DRAIN    = 2'b11
    } gate_state_e;

    typedef struct packed {
        logic enable;
        logic ref_clk;
    } pins_s;

    typedef struct packed {
        logic hiz;
        logic driven_low;
        logic running;
    } gate_status_s;

endpackage

// >>> design/pin_filter.sv
// pin_filter: three-stage synchroniser with agreement filter for board pins.
// assumes pins are asynchronous to clock; output changes only when stages two and three agree.
`timescale 1ns/1ps
module pin_filter
    import oe_gate_pkg::*;
#(
    parameter int                WIDTH = PIN_COUNT,
    parameter logic [WIDTH-1:0]  INIT  = '0
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             nrst,
    // raw pins
    input  wire logic [WIDTH-1:0] pin_in,
    // filtered levels
    output logic      [WIDTH-1:0] level
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_level;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // stage1 feeds stage2 only
            always_comb begin
                next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stage1 <= INIT;
            stage2 <= INIT;
            stage3 <= INIT;
            level  <= INIT;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= next_level;
        end
    end

endmodule

// >>> design/clock_output_enable_gate.sv
// clock_output_enable_gate: glitch-free enable gating of the buffered clock outputs.
// assumes the reference clock and enable pin come from the board, both far slower than clock.
// Summary of operation
// - a falling enable while the reference runs floats the outputs only after the next falling reference edge.
// - the outputs stay floating for as long as enable stays low.
// - a rising enable while floating drives all outputs low at once, with no reference edge needed.
// - after enabling, toggling resumes on a falling reference edge, at most two reference cycles later.
// - with the reference static and the outputs floating, a rising enable still drives them low.
// - with the reference static, a falling enable alone never floats the outputs again; a falling edge is needed.
`timescale 1ns/1ps
module clock_output_enable_gate
    import oe_gate_pkg::*;
#(
    parameter int N = NUM_OUTPUTS
) (
    // clock and reset
    input  wire logic          clock,
    input  wire logic          nrst,
    // board pins
    input  wire logic          ref_clk_in,
    input  wire logic          output_enable,
    // buffered clock outputs, two signals per pin
    output logic      [N-1:0]  clk_out,
    output logic      [N-1:0]  clk_out_oe,
    // observed state
    output gate_status_s       status
);

    pins_s        raw_pins;
    pins_s        pins;
    logic         ref_prev;
    logic         ref_fall;
    gate_state_e  state;
    gate_state_e  next_state;
    logic         next_ref_prev;
    logic [N-1:0] next_clk_out;
    logic [N-1:0] next_clk_out_oe;
    gate_status_s next_status;

    // replicates one level onto every output so all pins switch together
    function automatic logic [N-1:0] fan(input logic bit_in);
        fan = {N{bit_in}};
    endfunction

    // one-hot view of a state; draining still toggles, so it reports as running
    function automatic gate_status_s status_of(input gate_state_e s);
        status_of = '0;
        case (s)
            ST_HIZ: begin
                status_of.hiz = 1'b1;
            end
            ST_LOW: begin
                status_of.driven_low = 1'b1;
            end
            ST_RUN, ST_DRAIN: begin
                status_of.running = 1'b1;
            end
            default: begin
                status_of.hiz = 1'b1;
            end
        endcase
    endfunction

    // pins float only in the floating state
    function automatic logic drives(input gate_state_e s);
        drives = (s != ST_HIZ);
    endfunction

    always_comb begin
        raw_pins.enable  = output_enable;
        raw_pins.ref_clk = ref_clk_in;
    end

    pin_filter #(
        .WIDTH (PIN_COUNT),
        .INIT  (PIN_RESET)
    ) u_pin_filter (
        .clock  (clock),
        .nrst   (nrst),
        .pin_in (raw_pins),
        .level  (pins)
    );

    // edge detection on the filtered level only
    always_comb begin
        next_ref_prev = pins.ref_clk;
        ref_fall      = ref_prev & ~pins.ref_clk;
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_HIZ: begin
                if (pins.enable) begin
                    next_state = ST_LOW;
                end else begin
                    next_state = ST_HIZ;
                end
            end
            ST_LOW: begin
                // no reference edge: remain low whatever enable does
                if (ref_fall && pins.enable) begin
                    next_state = ST_RUN;
                end else if (ref_fall) begin
                    next_state = ST_HIZ;
                end
            end
            ST_RUN: begin
                if (!pins.enable) begin
                    next_state = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                // keep toggling until the low half starts, so no runt pulse
                if (ref_fall) begin
                    next_state = pins.enable ? ST_RUN : ST_HIZ;
                end else if (pins.enable) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_HIZ;
            end
        endcase
    end

    // outputs follow the next state so a change lands on the same edge as the state
    always_comb begin
        next_clk_out    = fan(LEVEL_LOW);
        next_clk_out_oe = fan(drives(next_state));
        next_status     = status_of(next_state);
        case (next_state)
            ST_HIZ: begin
                next_clk_out_oe = fan(1'b0);
            end
            ST_LOW: begin
                next_clk_out    = fan(LEVEL_LOW);
                next_clk_out_oe = fan(1'b1);
            end
            ST_RUN, ST_DRAIN: begin
                // entry from low happens on a falling edge, so the first level is low
                next_clk_out    = fan(pins.ref_clk);
                next_clk_out_oe = fan(1'b1);
            end
            default: begin
                next_clk_out_oe = fan(1'b0);
            end
        endcase
    end

    // edge history; resets to the filter's reset level so no false edge follows reset
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ref_prev <= 1'b0;
        end else begin
            ref_prev <= next_ref_prev;
        end
    end

    // gate state
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= ST_HIZ;
        end else begin
            state <= next_state;
        end
    end

    // pin-facing outputs come straight from flops so they never glitch
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            clk_out    <= '0;
            clk_out_oe <= '0;
            status     <= '0;
        end else begin
            clk_out    <= next_clk_out;
            clk_out_oe <= next_clk_out_oe;
            status     <= next_status;
        end
    end

endmodule

// >>> verification/oe_gate_props.sv
// oe_gate_props: checker on the gate's ports.
// assumes a slow reference from board logic.
`timescale 1ns/1ps
module oe_gate_props
    import oe_gate_pkg::*;
#(parameter int N = NUM_OUTPUTS) (
    // watched ports
    input wire logic         clock,
    input wire logic         nrst,
    input wire logic         ref_clk_in,
    input wire logic         output_enable,
    input wire logic [N-1:0] clk_out,
    input wire logic [N-1:0] clk_out_oe,
    input wire gate_status_s status
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    same_enable_a: assert property (clk_out_oe == '0 || clk_out_oe == '1) else $error("enables differ");
    float_view_a: assert property (status != '0 |-> status.hiz == (clk_out_oe == '0)) else $error("float view");
    same_level_a: assert property (clk_out == '0 || clk_out == '1) else $error("levels differ");
    hold_float_a: assert property ((!output_enable)[*6] ##0 status.hiz |=> status.hiz) else $error("left float");
    drive_low_a: assert property ($rose(output_enable) && status.hiz |-> ##[1:8]
        (clk_out_oe == '1 && clk_out == '0)) else $error("no drive low");
    idle_low_a: assert property (!status.running |-> clk_out == '0) else $error("idle not low");
    resume_run_a: assert property (status.driven_low && output_enable && $fell(ref_clk_in) |-> ##[1:8]
        status.running) else $error("no resume");
    static_keep_a: assert property ($stable(ref_clk_in)[*8] ##0 clk_out_oe[0] |=> clk_out_oe[0])
        else $error("float without edge");
    float_cause_a: assert property ($fell(clk_out_oe[0]) |-> !$past(output_enable, 3))
        else $error("float while enabled");
    cover property (status.running);
    cover property (status.driven_low);
    cover property ($fell(clk_out_oe[0]));
endmodule

bind clock_output_enable_gate oe_gate_props #(.N(N)) u_props (.clock(clock), .nrst(nrst),
    .ref_clk_in(ref_clk_in), .output_enable(output_enable), .clk_out(clk_out),
    .clk_out_oe(clk_out_oe), .status(status));

// >>> verification/ref_source.sv
// ref_source: board logic driving reference and enable pins.
// assumes bench requests change at the falling edge.
`timescale 1ns/1ps
module ref_source (
    // bench requests
    input wire logic clock,
    input wire logic run,
    input wire logic en_req,
    // board pins
    output logic     ref_clk_in,
    output logic     output_enable
);
    logic [2:0] tick = 3'h0;
    initial ref_clk_in = 1'b0;
    initial output_enable = 1'b0;
    // period 16 clocks; held still when stopped, as a gated source would be
    always @(negedge clock) begin
        output_enable <= en_req;
        if (run) begin
            tick <= tick + 3'h1;
            if (tick == 3'h7) ref_clk_in <= ~ref_clk_in;
        end
    end
endmodule

// >>> verification/tb_clock_output_enable_gate.sv
// tb_clock_output_enable_gate: enable rows, then reset and static-reference cases.
// assumes ref_source drives both pins.
`timescale 1ns/1ps
module tb_clock_output_enable_gate;
    import oe_gate_pkg::*;
    typedef struct packed {logic en; logic run; gate_status_s st;} row_s;
    logic                   clock = 1'b0;
    logic                   nrst = 1'b0;
    logic                   run = 1'b1;
    logic                   en_req = 1'b0;
    logic                   ref_clk_in;
    logic                   output_enable;
    logic [NUM_OUTPUTS-1:0] clk_out;
    logic [NUM_OUTPUTS-1:0] clk_out_oe;
    gate_status_s           status;
    int                     num_errors = 0;
    int                     n_compared = 0;
    int                     cycles = 0;
    int                     k;
    logic                   hi;
    logic                   lo;
    row_s                   rows [3] = '{'{1'b1, 1'b1, 3'h1}, '{1'b0, 1'b1, 3'h4}, '{1'b1, 1'b1, 3'h1}};
    always #50 clock = ~clock;
    ref_source partner (.clock(clock), .run(run), .en_req(en_req), .ref_clk_in(ref_clk_in),
        .output_enable(output_enable));
    clock_output_enable_gate dut (.clock(clock), .nrst(nrst), .ref_clk_in(ref_clk_in),
        .output_enable(output_enable), .clk_out(clk_out), .clk_out_oe(clk_out_oe), .status(status));
    task automatic check(input gate_status_s exp);
        n_compared++;
        if (status !== exp || clk_out_oe !== {NUM_OUTPUTS{exp != 3'h4}} || (!exp.running && clk_out !== '0)) begin
            num_errors++;
            $display("ERROR status expected %h seen %h", exp, status);
        end
    endtask
    task automatic settle(input gate_status_s exp, input int lim);
        for (k = 0; k < lim && status !== exp; k++) @(negedge clock);
    endtask
    task automatic end_sim;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ceiling well above the at most 525 cycles the cases take
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        repeat (3) @(negedge clock);
        n_compared++;
        if (status !== 3'h0 || clk_out_oe !== '0) begin
            num_errors++;
            $display("ERROR reset expected 0 seen %h", status);
        end
        nrst = 1'b1;
        foreach (rows[i]) begin
            en_req = rows[i].en;
            run = rows[i].run;
            settle(rows[i].st, 60);
            check(rows[i].st);
            // two reference periods plus pin sampling
            if (rows[i].st.running && k > 38) check(3'h0);
            if (rows[i].st.running) begin
                hi = 1'b0;
                lo = 1'b0;
                repeat (20) begin
                    @(negedge clock);
                    hi = hi | (clk_out === '1);
                    lo = lo | (clk_out === '0);
                end
                n_compared++;
                if (!(hi && lo)) begin
                    num_errors++;
                    $display("ERROR clk_out expected toggling seen %h", clk_out);
                end
            end
        end
        en_req = 1'b0;
        settle(3'h4, 60);
        run = 1'b0;
        repeat (20) @(negedge clock);
        en_req = 1'b1;
        settle(3'h2, 20);
        check(3'h2);
        en_req = 1'b0;
        repeat (40) @(negedge clock);
        check(3'h2);
        run = 1'b1;
        settle(3'h4, 40);
        check(3'h4);
        // second reset while running
        en_req = 1'b1;
        settle(3'h1, 60);
        nrst = 1'b0;
        @(negedge clock);
        n_compared++;
        if (status !== 3'h0 || clk_out_oe !== '0 || clk_out !== '0) begin
            num_errors++;
            $display("ERROR mid reset expected 0 seen %h", status);
        end
        nrst = 1'b1;
        @(negedge clock);
        check(3'h4);
        settle(3'h1, 60);
        check(3'h1);
        end_sim();
    end
endmodule
